// *** pkg/cpr_pkg.sv ***
// Package for the conveyor PLC I/O register map.
// Assumes one 25 MHz clock, with every status input coming from logic on that clock.
`default_nettype none

package cpr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;            // Widest offset fits in 8 bits
  localparam int unsigned DATA_W = 16;           // All map words are 16 bits

  localparam logic [7:0] LEFT_SERVO_STATE_A     = 8'h0B;
  localparam logic [7:0] RIGHT_SERVO_STATE_A    = 8'h10;
  localparam logic [7:0] STOP_GROUP_CMD_A       = 8'h14;
  localparam logic [7:0] MOTOR_FAULT_CLEAR_A    = 8'h16;
  localparam logic [7:0] SENSOR_PORT_CTRL_A     = 8'h25;
  localparam logic [7:0] RIGHT_PORT_CTRL_A      = 8'h30;
  localparam logic [7:0] LEFT_PORT_SHARED_A     = 8'h3C;  // Read: fault state, write: control
  localparam logic [7:0] LEFT_SERVO_POS_A       = 8'h3E;
  localparam logic [7:0] RIGHT_PORT_FAULT_A     = 8'h54;
  localparam logic [7:0] RIGHT_SERVO_POS_A      = 8'h56;
  localparam logic [7:0] UP_NEIGHBOUR_STATE_A   = 8'h86;
  localparam logic [7:0] UP_CARTON_TAG_LO_A     = 8'h8B;
  localparam logic [7:0] UP_CARTON_TAG_HI_A     = 8'h8C;
  localparam logic [7:0] DOWN_NEIGHBOUR_STATE_A = 8'hE8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned FAULT_SHORT_BIT  = 12;
  localparam int unsigned FAULT_OVER_BIT   = 14;
  localparam int unsigned SERVO_DONE_BIT   = 0;
  localparam int unsigned SERVO_RST_BIT    = 1;
  localparam int unsigned SERVO_CMD_BIT    = 2;
  localparam int unsigned PORT_PIN_A_BIT   = 1;   // Left pin 4, right pin 2
  localparam int unsigned PORT_PIN3_BIT    = 2;
  localparam int unsigned PORT_DIGITAL_BIT = 15;
  localparam int unsigned SENS_L_ON_BIT    = 0;
  localparam int unsigned SENS_R_ON_BIT    = 1;
  localparam int unsigned SENS_L_OUT_BIT   = 5;
  localparam int unsigned SENS_R_OUT_BIT   = 6;

  // Writable bits of the control words; the rest are dropped
  localparam logic [15:0] PORT_CTRL_MASK   = 16'h8006;
  localparam logic [15:0] SENSOR_CTRL_MASK = 16'h0063;

  // ----------------------------------------------------------------
  // Command values, zone codes, reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] STOP_CMD_NONE    = 16'h0000;
  localparam logic [15:0] STOP_CMD_STOP    = 16'h0001;
  localparam logic [15:0] STOP_CMD_RELEASE = 16'h0002;
  localparam logic [15:0] FAULT_CLEAR_ON   = 16'h0001;
  localparam logic [15:0] WORD_RESET       = 16'h0000;

  localparam logic [7:0] ZONE_CLEAR_STOPPED  = 8'h01;
  localparam logic [7:0] ZONE_CLEAR_RUNNING  = 8'h02;
  localparam logic [7:0] ZONE_BLOCKED_RUN    = 8'h04;
  localparam logic [7:0] ZONE_BLOCKED_STOP   = 8'h05;
  localparam logic [7:0] ZONE_BUSY           = 8'h06;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CPR_GRP_RUNNING = 2'b01,
    CPR_GRP_STOPPED = 2'b10
  } cpr_group_state_t;

  typedef struct packed {
    logic shorted;       // Any output shorted
    logic overcurrent;   // Any output above 1A
  } cpr_port_fault_t;

  typedef struct packed {
    logic blocked;       // Zone sensor blocked
    logic running;       // Zone motor running
    logic busy;          // Stop group busy
  } cpr_zone_t;

  typedef struct packed {
    logic      update;   // One-cycle refresh strobe from the neighbour
    cpr_zone_t zone_hi;  // Reported in the high byte
    cpr_zone_t zone_lo;  // Reported in the low byte
  } cpr_neighbour_t;

  typedef struct packed {
    logic        done;   // Last servo run finished
    logic [1:0]  cmd;    // Servo command word bits 1..0
    logic [15:0] pos;    // Signed position from the zero reference
  } cpr_servo_t;

endpackage

`default_nettype wire

// *** hdl/cpr_register_map.sv ***
// Conveyor PLC I/O register map: status words to the PLC, control words from it.
// Assumes the fieldbus side presents single-cycle read and write strobes on core_clk.
//
// Notes on behaviour
// - Fault word: bit12 short, bit14 over 1A
// - Zone byte 01 clear stopped, 02 clear running
// - Zone byte 04 discharging, 05 blocked, 06 busy
// - Two tracking words hold last upstream carton
// - Neighbour words update only while links retained
// - Servo position is signed 16-bit from zero
// - Servo status bit0: one when run complete
// - Servo status bits 1,2 echo command bits
// - Stop word: 0 none, 1 stop, 2 release
// - Fault reset active while clear word holds 1
// - Left port: bit1 pin 4, bit2 pin 3
// - Right port: bit1 pin 2, bit2 pin 3
// - Bit15 picks motor drive or digital outputs
// - Sensor bits 0,1 switch left/right pin 2
// - Sensor bits 5,6 make pin 2 an output
`timescale 1ns/10ps
`default_nettype none

module cpr_register_map
  import cpr_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  // Register access from the fieldbus assemblies
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  input  wire logic                  reg_rd,
  output logic [DATA_W-1:0]          reg_rdata,
  output logic                       reg_rvalid,
  // Motor port fault sense
  input  wire cpr_port_fault_t       left_port_fault,
  input  wire cpr_port_fault_t       right_port_fault,
  // Neighbour links
  input  wire logic                  links_retained,
  input  wire cpr_neighbour_t        up_neighbour,
  input  wire cpr_neighbour_t        down_neighbour,
  input  wire logic                  up_tag_update,
  input  wire logic [31:0]           up_tag,
  // Servo feedback
  input  wire cpr_servo_t            left_servo,
  input  wire cpr_servo_t            right_servo,
  // Stop group and fault reset
  output logic                       group_stopped,
  output logic                       motor_fault_reset,
  // Motor port pins
  output logic                       left_port_digital,
  output logic                       left_pin4_drive,
  output logic                       left_pin3_drive,
  output logic                       right_port_digital,
  output logic                       right_pin2_drive,
  output logic                       right_pin3_drive,
  // Sensor port pin 2 (enable low while driving)
  output logic                       left_sens_pin2_out,
  output logic                       left_sens_pin2_oe_n,
  output logic                       right_sens_pin2_out,
  output logic                       right_sens_pin2_oe_n
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  cpr_group_state_t  grp_q;             // Stop group state
  logic [15:0]       stop_cmd_q;        // Last stop command word
  logic [15:0]       fault_clear_q;     // Motor error clear word
  logic [15:0]       left_ctrl_q;       // Left port control, masked
  logic [15:0]       right_ctrl_q;      // Right port control, masked
  logic [15:0]       sensor_ctrl_q;     // Sensor port control, masked
  logic [15:0]       up_state_q;        // Upstream neighbour codes
  logic [15:0]       down_state_q;      // Downstream neighbour codes
  logic [15:0]       tag_lo_q;          // Carton tag, first word
  logic [15:0]       tag_hi_q;          // Carton tag, second word
  logic [15:0]       rdata_q;           // Registered read data
  logic              rvalid_q;          // Read answer strobe

  // ----------------------------------------------------------------
  // Zone code encoder
  // ----------------------------------------------------------------
  // Busy outranks the sensor state: the stop group owns the zone then
  function automatic logic [7:0] zone_code(input cpr_zone_t z);
    logic [7:0] c;
    c = ZONE_CLEAR_STOPPED;
    if (z.busy) begin
      c = ZONE_BUSY;
    end else if (z.blocked) begin
      c = z.running ? ZONE_BLOCKED_RUN : ZONE_BLOCKED_STOP;
    end else if (z.running) begin
      c = ZONE_CLEAR_RUNNING;
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire logic wr_stop    = reg_wr && (reg_addr == STOP_GROUP_CMD_A);
  wire logic wr_fclr    = reg_wr && (reg_addr == MOTOR_FAULT_CLEAR_A);
  wire logic wr_left    = reg_wr && (reg_addr == LEFT_PORT_SHARED_A);
  wire logic wr_right   = reg_wr && (reg_addr == RIGHT_PORT_CTRL_A);
  wire logic wr_sensor  = reg_wr && (reg_addr == SENSOR_PORT_CTRL_A);
  wire logic stop_req   = wr_stop && (reg_wdata == STOP_CMD_STOP);
  wire logic rel_req    = wr_stop && (reg_wdata == STOP_CMD_RELEASE);

  // Neighbour refreshes pass only over retained links
  wire logic up_upd     = links_retained && up_neighbour.update;
  wire logic down_upd   = links_retained && down_neighbour.update;
  wire logic tag_upd    = links_retained && up_tag_update;

  // ----------------------------------------------------------------
  // Read-side word assembly
  // ----------------------------------------------------------------
  wire logic [15:0] left_fault_w  = 16'(left_port_fault.shorted) << FAULT_SHORT_BIT
                                  | 16'(left_port_fault.overcurrent) << FAULT_OVER_BIT;
  wire logic [15:0] right_fault_w = 16'(right_port_fault.shorted) << FAULT_SHORT_BIT
                                  | 16'(right_port_fault.overcurrent) << FAULT_OVER_BIT;
  wire logic [15:0] left_servo_w  = 16'(left_servo.done) << SERVO_DONE_BIT
                                  | 16'(left_servo.cmd[0]) << SERVO_RST_BIT
                                  | 16'(left_servo.cmd[1]) << SERVO_CMD_BIT;
  wire logic [15:0] right_servo_w = 16'(right_servo.done) << SERVO_DONE_BIT
                                  | 16'(right_servo.cmd[0]) << SERVO_RST_BIT
                                  | 16'(right_servo.cmd[1]) << SERVO_CMD_BIT;

  // Read mux; unmapped offsets return zero
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = WORD_RESET;
    unique case (reg_addr)
      LEFT_SERVO_STATE_A:     rd_mux = left_servo_w;
      RIGHT_SERVO_STATE_A:    rd_mux = right_servo_w;
      STOP_GROUP_CMD_A:       rd_mux = stop_cmd_q;
      MOTOR_FAULT_CLEAR_A:    rd_mux = fault_clear_q;
      SENSOR_PORT_CTRL_A:     rd_mux = sensor_ctrl_q;
      RIGHT_PORT_CTRL_A:      rd_mux = right_ctrl_q;
      // Shared offset: software sees the fault word, not the control
      LEFT_PORT_SHARED_A:     rd_mux = left_fault_w;
      LEFT_SERVO_POS_A:       rd_mux = left_servo.pos;
      RIGHT_PORT_FAULT_A:     rd_mux = right_fault_w;
      RIGHT_SERVO_POS_A:      rd_mux = right_servo.pos;
      UP_NEIGHBOUR_STATE_A:   rd_mux = up_state_q;
      UP_CARTON_TAG_LO_A:     rd_mux = tag_lo_q;
      UP_CARTON_TAG_HI_A:     rd_mux = tag_hi_q;
      DOWN_NEIGHBOUR_STATE_A: rd_mux = down_state_q;
      default:                rd_mux = WORD_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q  <= WORD_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control words from the PLC
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stop_cmd_q    <= STOP_CMD_NONE;
      fault_clear_q <= WORD_RESET;
      left_ctrl_q   <= WORD_RESET;
      right_ctrl_q  <= WORD_RESET;
      sensor_ctrl_q <= WORD_RESET;
    end else begin
      if (wr_stop)   stop_cmd_q    <= reg_wdata;
      if (wr_fclr)   fault_clear_q <= reg_wdata;
      if (wr_left)   left_ctrl_q   <= reg_wdata & PORT_CTRL_MASK;
      if (wr_right)  right_ctrl_q  <= reg_wdata & PORT_CTRL_MASK;
      if (wr_sensor) sensor_ctrl_q <= reg_wdata & SENSOR_CTRL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Stop group state
  // ----------------------------------------------------------------
  // Acts on the write itself; a held word does not re-trigger
  always_ff @(posedge core_clk) begin
    if (reset) begin
      grp_q <= CPR_GRP_RUNNING;
    end else begin
      unique case (grp_q)
        CPR_GRP_RUNNING: if (stop_req) grp_q <= CPR_GRP_STOPPED;
        CPR_GRP_STOPPED: if (rel_req)  grp_q <= CPR_GRP_RUNNING;
        default:         grp_q <= CPR_GRP_RUNNING;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Neighbour status and tracking
  // ----------------------------------------------------------------
  // Cleared links wipe the words so stale codes are never shown
  always_ff @(posedge core_clk) begin
    if (reset) begin
      up_state_q   <= WORD_RESET;
      down_state_q <= WORD_RESET;
      tag_lo_q     <= WORD_RESET;
      tag_hi_q     <= WORD_RESET;
    end else if (!links_retained) begin
      up_state_q   <= WORD_RESET;
      down_state_q <= WORD_RESET;
      tag_lo_q     <= WORD_RESET;
      tag_hi_q     <= WORD_RESET;
    end else begin
      if (up_upd)   up_state_q   <= {zone_code(up_neighbour.zone_hi), zone_code(up_neighbour.zone_lo)};
      if (down_upd) down_state_q <= {zone_code(down_neighbour.zone_hi), zone_code(down_neighbour.zone_lo)};
      if (tag_upd) begin
        tag_lo_q <= up_tag[15:0];
        tag_hi_q <= up_tag[31:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata         = rdata_q;
  assign reg_rvalid        = rvalid_q;
  assign group_stopped     = (grp_q == CPR_GRP_STOPPED);
  assign motor_fault_reset = (fault_clear_q == FAULT_CLEAR_ON);

  // Pins follow their bits only in digital mode; else the motor owns them
  assign left_port_digital  = left_ctrl_q[PORT_DIGITAL_BIT];
  assign right_port_digital = right_ctrl_q[PORT_DIGITAL_BIT];
  assign left_pin4_drive    = left_port_digital && left_ctrl_q[PORT_PIN_A_BIT];
  assign left_pin3_drive    = left_port_digital && left_ctrl_q[PORT_PIN3_BIT];
  assign right_pin2_drive   = right_port_digital && right_ctrl_q[PORT_PIN_A_BIT];
  assign right_pin3_drive   = right_port_digital && right_ctrl_q[PORT_PIN3_BIT];

  // Sensor pin 2: level from the on bit, direction from the output bit
  assign left_sens_pin2_out   = sensor_ctrl_q[SENS_L_ON_BIT];
  assign right_sens_pin2_out  = sensor_ctrl_q[SENS_R_ON_BIT];
  assign left_sens_pin2_oe_n  = !sensor_ctrl_q[SENS_L_OUT_BIT];
  assign right_sens_pin2_oe_n = !sensor_ctrl_q[SENS_R_OUT_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  fault_bits_a: assert property (reg_rd && reg_addr == RIGHT_PORT_FAULT_A |=>
      rdata_q[FAULT_SHORT_BIT] == $past(right_port_fault.shorted)
      && rdata_q[FAULT_OVER_BIT] == $past(right_port_fault.overcurrent) && rvalid_q)
    else $error("fault word bits wrong");

  zone_clear_a: assert property (up_upd && !up_neighbour.zone_lo.busy && !up_neighbour.zone_lo.blocked
      |=> up_state_q[7:0] == (($past(up_neighbour.zone_lo.running)) ? 8'h02 : 8'h01))
    else $error("clear zone code wrong");

  zone_busy_a: assert property (down_upd && down_neighbour.zone_hi.busy
      |=> down_state_q[15:8] == 8'h06)
    else $error("busy zone code wrong");

  tag_capture_a: assert property (tag_upd ##1 !tag_upd |=>
      {tag_hi_q, tag_lo_q} == $past(up_tag, 2))
    else $error("tracking words not captured");

  link_clear_a: assert property (!links_retained |=>
      up_state_q == 16'h0000 && tag_hi_q == 16'h0000 && down_state_q == 16'h0000)
    else $error("neighbour words not cleared");

  servo_pos_a: assert property (reg_rd && reg_addr == LEFT_SERVO_POS_A |=>
      rdata_q == $past(left_servo.pos))
    else $error("servo position read wrong");

  servo_state_a: assert property (reg_rd && reg_addr == RIGHT_SERVO_STATE_A |=>
      rdata_q == {13'h0, $past(right_servo.cmd[1]), $past(right_servo.cmd[0]), $past(right_servo.done)})
    else $error("servo status read wrong");

  // A stop write leaves the group stopped whatever state it was in
  stop_group_a: assert property (stop_req |=> group_stopped)
    else $error("stop group did not stop");

  group_hold_a: assert property (group_stopped && !rel_req |=> group_stopped)
    else $error("stopped group left without release");

  running_hold_a: assert property (!group_stopped && !stop_req |=> !group_stopped)
    else $error("running group stopped without command");

  release_a: assert property (group_stopped && rel_req |=> !group_stopped)
    else $error("stop group did not release");

  fault_reset_a: assert property (wr_fclr && reg_wdata == 16'h0001 ##1 !wr_fclr
      |=> motor_fault_reset)
    else $error("fault reset not held");

  port_mode_a: assert property (wr_left && !reg_wdata[15] |=> !left_pin4_drive && !left_pin3_drive)
    else $error("motor mode still drives pins");

  left_pins_a: assert property (wr_left && reg_wdata == 16'h8002 |=> left_pin4_drive && !left_pin3_drive)
    else $error("left port pin map wrong");

  right_pins_a: assert property (wr_right && reg_wdata == 16'h8004 |=> right_pin3_drive && !right_pin2_drive)
    else $error("right port pin map wrong");

  sensor_pin_a: assert property (wr_sensor && reg_wdata == 16'h0021 |=>
      left_sens_pin2_out && !left_sens_pin2_oe_n && !right_sens_pin2_out && right_sens_pin2_oe_n)
    else $error("sensor pin control wrong");

  // Any read of the right control word, whatever was written before it
  reserved_zero_a: assert property (reg_rd && reg_addr == RIGHT_PORT_CTRL_A
      |=> rdata_q[14:3] == 12'h000 && rdata_q[0] == 1'b0)
    else $error("reserved bits read back");

  fault_withdraw_a: assert property (wr_fclr && reg_wdata == WORD_RESET |=> !motor_fault_reset)
    else $error("fault reset not withdrawn");

  right_mode_a: assert property (wr_right && !reg_wdata[PORT_DIGITAL_BIT]
      |=> !right_pin2_drive && !right_pin3_drive)
    else $error("right motor mode still drives pins");

  sensor_dir_a: assert property (wr_sensor && reg_wdata == 16'h0042 |=>
      right_sens_pin2_out && !right_sens_pin2_oe_n && !left_sens_pin2_out && left_sens_pin2_oe_n)
    else $error("sensor pin direction wrong");

  // With links retained and no refresh strobe, the upstream state and tag words must not move
  link_hold_a: assert property (links_retained && !up_upd && !tag_upd |=>
      $stable(up_state_q) && $stable(tag_lo_q) && $stable(tag_hi_q))
    else $error("neighbour words moved without refresh");

  stop_seen_c:    cover property (stop_req ##[1:20] rel_req);
  busy_seen_c:    cover property (up_upd && up_neighbour.zone_lo.busy);
  tag_seen_c:     cover property (tag_upd ##[1:10] reg_rd && reg_addr == UP_CARTON_TAG_HI_A);
  digital_mode_c: cover property (left_pin4_drive && right_pin2_drive);

endmodule // cpr_register_map

`default_nettype wire

// *** tb/cpr_plc_model.sv ***
// PLC-side model of the register bus: single-cycle writes and reads.
// Assumes the map samples reg_wr/reg_rd on the rising core_clk edge.
`timescale 1ns/10ps
`default_nettype none
module cpr_plc_model
  import cpr_pkg::*;
(
  // Clock
  input  wire logic              core_clk,
  // Register bus
  output logic [ADDR_W-1:0]      reg_addr,
  output logic                   reg_wr,
  output logic [DATA_W-1:0]      reg_wdata,
  output logic                   reg_rd,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              reg_rvalid
);
  // Idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'b0;
  end
  // One write; idle address and data are inverted so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge core_clk) #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // One read; answer awaited for a few cycles only
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output bit ok);
    ok = 1'b0;
    d  = 16'h0000;
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge core_clk) #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d  = reg_rdata;
      end else @(posedge core_clk) #1;
    end
  endtask
endmodule // cpr_plc_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the conveyor PLC I/O register map.
// Assumes cpr_pkg is compiled first and the PLC model drives the bus.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cpr_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk, reset, reg_wr, reg_rd, reg_rvalid, links_retained, up_tag_update;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [31:0] up_tag;
  cpr_port_fault_t left_port_fault, right_port_fault;
  cpr_neighbour_t up_neighbour, down_neighbour;
  cpr_servo_t left_servo, right_servo;
  logic group_stopped, motor_fault_reset, left_port_digital, left_pin4_drive, left_pin3_drive;
  logic right_port_digital, right_pin2_drive, right_pin3_drive, left_sens_pin2_out;
  logic left_sens_pin2_oe_n, right_sens_pin2_out, right_sens_pin2_oe_n;
  int num_errors, checks_done;
  // All pin outputs in one word, stop group at the top
  wire logic [11:0] outs = {group_stopped, motor_fault_reset, left_port_digital, left_pin4_drive,
    left_pin3_drive, right_port_digital, right_pin2_drive, right_pin3_drive, left_sens_pin2_out,
    left_sens_pin2_oe_n, right_sens_pin2_out, right_sens_pin2_oe_n};
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  cpr_register_map i_dut (.core_clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .left_port_fault, .right_port_fault, .links_retained, .up_neighbour,
    .down_neighbour, .up_tag_update, .up_tag, .left_servo, .right_servo, .group_stopped,
    .motor_fault_reset, .left_port_digital, .left_pin4_drive, .left_pin3_drive,
    .right_port_digital, .right_pin2_drive, .right_pin3_drive, .left_sens_pin2_out,
    .left_sens_pin2_oe_n, .right_sens_pin2_out, .right_sens_pin2_oe_n);
  cpr_plc_model i_plc (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid);
  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Read and compare; a lost answer ends the run
  task automatic rdc(logic [7:0] a, logic [15:0] exp);
    logic [15:0] d;
    bit ok;
    i_plc.rd(a, d, ok);
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED read %h expected answer seen none", a);
      conclude();
    end else chk($sformatf("read %h", a), d, exp);
  endtask
  task automatic oc(logic [11:0] exp);
    chk("pins", {4'h0, outs}, {4'h0, exp});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_stop();
    oc(12'h005); rdc(8'h00, 16'h0000);
    i_plc.wr(8'h14, 16'h0001); oc(12'h805);
    i_plc.wr(8'h14, 16'h0000); oc(12'h805);
    i_plc.wr(8'h14, 16'h0002); oc(12'h005);
    i_plc.wr(8'h16, 16'h0001); oc(12'h405);
    i_plc.wr(8'h16, 16'h0000); oc(12'h005);
    $display("test_stop done");
  endtask
  task automatic test_sensor();
    i_plc.wr(8'h25, 16'hFFFF); oc(12'h00A);
    rdc(8'h25, 16'h0063);
    i_plc.wr(8'h25, 16'h0021); oc(12'h009);
    i_plc.wr(8'h25, 16'h0042); oc(12'h006);
    i_plc.wr(8'h25, 16'h0000); oc(12'h005);
    $display("test_sensor done");
  endtask
  task automatic test_ports();
    i_plc.wr(8'h3C, 16'h7FFF); oc(12'h005);
    i_plc.wr(8'h3C, 16'hFFFF); oc(12'h385);
    i_plc.wr(8'h3C, 16'h8002); oc(12'h305);
    i_plc.wr(8'h30, 16'h8004); oc(12'h355);
    i_plc.wr(8'h30, 16'h0006); oc(12'h305);
    i_plc.wr(8'h30, 16'hFFFF); oc(12'h375); rdc(8'h30, 16'h8006);
    $display("test_ports done");
  endtask
  task automatic test_status();
    left_port_fault = '{1'b1, 1'b0};
    right_port_fault = '{1'b0, 1'b1};
    left_servo = '{1'b1, 2'b10, 16'h8001};
    right_servo = '{1'b0, 2'b01, 16'h7FFE};
    rdc(8'h3C, 16'h1000); rdc(8'h54, 16'h4000);
    left_port_fault = '{1'b1, 1'b1};
    rdc(8'h3C, 16'h5000);
    rdc(8'h0B, 16'h0005); rdc(8'h10, 16'h0002);
    rdc(8'h3E, 16'h8001); rdc(8'h56, 16'h7FFE);
    $display("test_status done");
  endtask
  // Strobe both neighbours, and the tag when tg is set, for one cycle
  task automatic pulse(logic tg);
    @(posedge core_clk) #1;
    up_neighbour.update = 1'b1;
    down_neighbour.update = 1'b1;
    up_tag_update = tg;
    @(posedge core_clk) #1;
    up_neighbour.update = 1'b0;
    down_neighbour.update = 1'b0;
    up_tag_update = 1'b0;
  endtask
  task automatic test_neighbour();
    cpr_zone_t zt[5] = '{3'b000, 3'b010, 3'b110, 3'b100, 3'b001};
    logic [7:0] ct[5] = '{ZONE_CLEAR_STOPPED, ZONE_CLEAR_RUNNING, ZONE_BLOCKED_RUN,
                          ZONE_BLOCKED_STOP, ZONE_BUSY};
    for (int i = 0; i < 5; i++) begin
      up_neighbour = {1'b0, zt[i], zt[(i+1)%5]};
      down_neighbour = {1'b0, zt[(i+2)%5], zt[i]};
      pulse(1'b0);
      rdc(8'h86, {ct[i], ct[(i+1)%5]});
      rdc(8'hE8, {ct[(i+2)%5], ct[i]});
    end
    up_tag = 32'hA5C3_1E72;
    pulse(1'b1);
    rdc(8'h8B, 16'h1E72); rdc(8'h8C, 16'hA5C3);
    links_retained = 1'b0;
    pulse(1'b1);
    rdc(8'h86, 16'h0000); rdc(8'h8C, 16'h0000);
    links_retained = 1'b1; rdc(8'h8B, 16'h0000);
    $display("test_neighbour done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0;
    checks_done = 0;
    reset = 1'b1;
    links_retained = 1'b1;
    up_tag_update = 1'b0;
    up_tag = 32'h0000_0000;
    left_port_fault = '0;
    right_port_fault = '0;
    up_neighbour = '0;
    down_neighbour = '0;
    left_servo = '0;
    right_servo = '0;
    repeat (12) @(posedge core_clk);
    #1 reset = 1'b0;
    test_stop();
    test_sensor();
    test_ports();
    test_status();
    test_neighbour();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
